// *** common/srs_consts.vh ***
// Constants for the serial port status and rate select block.
// Assumes a 32-bit register bus with byte addresses in the low eight bits.
`ifndef SRS_CONSTS_VH
`define SRS_CONSTS_VH

// Register byte offsets.
`define SRS_OFF_CONTROL 8'hC0
`define SRS_OFF_STATUS 8'hC4
`define SRS_OFF_DATA 8'hC8
`define SRS_OFF_IRQ_STATUS 8'hCC
`define SRS_OFF_IRQ_MASK 8'hD0

// Control register fields and reset value.
`define SRS_CTL_RATE2 7
`define SRS_CTL_ENABLE 6
`define SRS_CTL_SS_DISABLE 5
`define SRS_CTL_MASTER 4
`define SRS_CTL_CPOL 3
`define SRS_CTL_CPHA 2
`define SRS_CTL_RATE1 1
`define SRS_CTL_RATE0 0
`define SRS_CONTROL_RESET 8'h14

// Status register fields; interrupt status and mask share this layout.
`define SRS_ST_DONE 7
`define SRS_ST_COLLISION 6
`define SRS_ST_SLAVE_ERROR 5
`define SRS_ST_MODE_FAULT 4

// Timing counts: bits per byte and the largest rate code in use.
`define SRS_BITS_PER_BYTE 4'h8
`define SRS_RATE_MAX 3'h6

`endif

// *** rtl/srs_rate_div.v ***
// Serial clock rate divider: emits one tick per half serial clock period.
// Assumes run is a level from the same clock domain.
`timescale 1ns/10ps
`include "srs_consts.vh"

module srs_rate_div #(
    parameter CW = 6
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [2:0] rate,
    output wire tick
);
    reg [CW-1:0] count;
    wire [2:0] code;
    wire [CW-1:0] half_m1;

    // Code 111 is invalid; it is held to the slowest valid rate.
    assign code = (rate > `SRS_RATE_MAX) ? `SRS_RATE_MAX : rate;
    // Half period is 2 to the power of the code, so the full period is
    // 2, 4, 8, 16, 32, 64 or 128 clocks.
    assign half_m1 = ({{(CW-1){1'b0}}, 1'b1} << code) - {{(CW-1){1'b0}}, 1'b1};
    assign tick = run && (count == half_m1);

    always @(posedge clk) begin
        if (rst || !run || tick) begin
            count <= {CW{1'b0}};
        end else begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule // srs_rate_div

// *** rtl/srs_spi.v ***
// Serial port with status flags, rate select and an APB register slave.
// Assumes a single clock; pins from the link are synchronised here.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "srs_consts.vh"

// Summary of operation
// - Rate code 101 divides the clock by 64, 110 by 128; 111 invalid.
// - Rate codes 000 to 100 divide the clock by 2, 4, 8, 16, 32.
// - Control register resets to 0001 0100; only whole-register access.
// - Status holds transfer done, write collision, slave error and mode fault flags.
// - Done flag bit 7 sets at byte end, clears at start or sequence.
// - Collision flag bit 6 sets on collision, clears by the sequence.
// - Slave error bit 5 sets on early deselect; clears when disabled.
// - Mode fault bit 4 follows a bad select level or the sequence.
module srs_spi (
    input wire CLOCK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    output reg IRQ,
    input wire SCK_IN,
    output wire SCK_OUT,
    output wire SCK_OE_N,
    input wire MOSI_IN,
    output wire MOSI_OUT,
    output wire MOSI_OE_N,
    input wire MISO_IN,
    output wire MISO_OUT,
    output wire MISO_OE_N,
    input wire SS_N_IN
);
    // Register state.
    reg [7:0] spi_control;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    reg [7:0] rx_buf;
    reg transfer_done_flag;
    reg write_collision_flag;
    reg slave_select_error_flag;
    reg mode_fault_flag;
    reg seq_armed;
    reg fault_d;

    // Shift engine state.
    reg [7:0] shreg;
    reg [7:0] rx_sh;
    reg [3:0] bit_cnt;
    reg busy;
    reg sck_lvl;
    reg out_bit;

    // Pin synchronisers: bit 0 sck, 1 ss, 2 mosi, 3 miso.
    reg [3:0] pin_s1;
    reg [3:0] pin_s2;
    reg sck_prev;
    reg ss_prev;
    wire [3:0] pins;

    assign pins = {MISO_IN, MOSI_IN, SS_N_IN, SCK_IN};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge CLOCK) begin
                if (RESET) begin
                    pin_s1[gi] <= 1'b1;
                    pin_s2[gi] <= 1'b1;
                end else begin
                    pin_s1[gi] <= pins[gi];
                    pin_s2[gi] <= pin_s1[gi];
                end
            end
        end
    endgenerate

    always @(posedge CLOCK) begin
        if (RESET) begin
            sck_prev <= 1'b1;
            ss_prev <= 1'b1;
        end else begin
            sck_prev <= pin_s2[0];
            ss_prev <= pin_s2[1];
        end
    end

    // Bus decode.
    wire setup_ph;
    wire acc;
    wire wr;
    wire rd;
    wire hit_ctl;
    wire hit_st;
    wire hit_data;
    wire hit_ist;
    wire hit_imask;
    wire mapped;

    assign setup_ph = PSEL && !PENABLE;
    assign acc = PSEL && PENABLE;
    assign wr = acc && PWRITE;
    assign rd = acc && !PWRITE;
    assign hit_ctl = (PADDR == `SRS_OFF_CONTROL);
    assign hit_st = (PADDR == `SRS_OFF_STATUS);
    assign hit_data = (PADDR == `SRS_OFF_DATA);
    assign hit_ist = (PADDR == `SRS_OFF_IRQ_STATUS);
    assign hit_imask = (PADDR == `SRS_OFF_IRQ_MASK);
    assign mapped = hit_ctl || hit_st || hit_data || hit_ist || hit_imask;
    assign PREADY = 1'b1;
    assign PSLVERR = acc && !mapped;

    // Mode decode from the control register.
    wire en;
    wire m_mode;
    wire s_mode;
    wire cpol;
    wire cpha;
    wire [2:0] rate;

    assign en = spi_control[`SRS_CTL_ENABLE];
    assign m_mode = en && spi_control[`SRS_CTL_MASTER];
    assign s_mode = en && !spi_control[`SRS_CTL_MASTER];
    assign cpol = spi_control[`SRS_CTL_CPOL];
    assign cpha = spi_control[`SRS_CTL_CPHA];
    assign rate = {spi_control[`SRS_CTL_RATE2],
                   spi_control[`SRS_CTL_RATE1],
                   spi_control[`SRS_CTL_RATE0]};

    // Rate tick.
    wire tick;

    srs_rate_div #(
        .CW(6)
    ) u_div (
        .clk(CLOCK),
        .rst(RESET),
        .run(busy && m_mode),
        .rate(rate),
        .tick(tick)
    );

    // Edge events for both roles.
    wire selected;
    wire ss_fall;
    wire ss_rise;
    wire sck_chg;
    wire lead;
    wire trail;
    wire sample;
    wire shift_ev;
    wire rx_in;
    wire data_wr;
    wire data_acc;
    wire busy_any;
    wire start;
    wire wr_coll;
    wire [3:0] cnt_inc;
    wire m_done;
    wire s_done;
    wire done;
    wire seq_clear;
    wire fault_cond;
    wire slave_select_error_flag_set;
    wire mode_fault_flag_set;
    wire [7:0] rx_next;

    assign selected = s_mode && !pin_s2[1];
    assign ss_fall = s_mode && ss_prev && !pin_s2[1];
    assign ss_rise = pin_s2[1] && !ss_prev;
    assign sck_chg = pin_s2[0] != sck_prev;
    assign lead = m_mode ? (busy && tick && (sck_lvl == cpol))
                         : (selected && sck_chg && (pin_s2[0] != cpol));
    assign trail = m_mode ? (busy && tick && (sck_lvl != cpol))
                          : (selected && sck_chg && (pin_s2[0] == cpol));
    assign sample = cpha ? trail : lead;
    assign shift_ev = cpha ? lead : trail;
    assign rx_in = m_mode ? pin_s2[3] : pin_s2[2];
    assign data_wr = wr && hit_data;
    assign data_acc = acc && hit_data;
    assign busy_any = m_mode ? busy : (bit_cnt != 4'h0);
    assign start = m_mode && data_wr && !busy;
    assign wr_coll = data_wr && en && busy_any;
    assign cnt_inc = bit_cnt + {3'h0, sample};
    assign m_done = m_mode && trail && (cnt_inc == `SRS_BITS_PER_BYTE);
    assign s_done = s_mode && sample
                    && (cnt_inc == `SRS_BITS_PER_BYTE);
    assign done = m_done || s_done;
    assign rx_next = sample ? {rx_sh[6:0], rx_in} : rx_sh;
    assign seq_clear = seq_armed && data_acc;
    assign fault_cond = m_mode && !spi_control[`SRS_CTL_SS_DISABLE]
                        && !pin_s2[1];
    assign mode_fault_flag_set = fault_cond && !fault_d;
    assign slave_select_error_flag_set = s_mode && ss_rise && (bit_cnt != 4'h0);

    // Shift engine.
    always @(posedge CLOCK) begin
        if (RESET) begin
            shreg <= 8'h00;
            rx_sh <= 8'h00;
            rx_buf <= 8'h00;
            bit_cnt <= 4'h0;
            busy <= 1'b0;
            sck_lvl <= 1'b0;
            out_bit <= 1'b0;
        end else if (!en) begin
            busy <= 1'b0;
            bit_cnt <= 4'h0;
            sck_lvl <= cpol;
        end else if (start) begin
            busy <= 1'b1;
            bit_cnt <= 4'h0;
            sck_lvl <= cpol;
            if (!cpha) begin
                out_bit <= PWDATA[7];
                shreg <= {PWDATA[6:0], 1'b0};
            end else begin
                shreg <= PWDATA[7:0];
            end
        end else begin
            if (s_mode && data_wr && !busy_any) begin
                shreg <= PWDATA[7:0];
            end
            if (m_mode && tick) begin
                sck_lvl <= ~sck_lvl;
            end
            // Select fall starts a phase-zero slave byte.
            if (ss_fall && !cpha) begin
                out_bit <= shreg[7];
                shreg <= {shreg[6:0], 1'b0};
                bit_cnt <= 4'h0;
            end else if (shift_ev && !done) begin
                out_bit <= shreg[7];
                shreg <= {shreg[6:0], 1'b0};
            end
            if (sample) begin
                rx_sh <= rx_next;
                bit_cnt <= cnt_inc;
            end
            if (done) begin
                rx_buf <= rx_next;
                busy <= 1'b0;
                bit_cnt <= 4'h0;
            end else if (s_mode && ss_rise) begin
                bit_cnt <= 4'h0;
            end
        end
    end

    // Status flags; a set in the same cycle beats a clear.
    always @(posedge CLOCK) begin
        if (RESET) begin
            transfer_done_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            slave_select_error_flag <= 1'b0;
            mode_fault_flag <= 1'b0;
            fault_d <= 1'b0;
            seq_armed <= 1'b0;
        end else begin
            fault_d <= fault_cond;
            if (done) begin
                transfer_done_flag <= 1'b1;
            end else if (start || seq_clear) begin
                transfer_done_flag <= 1'b0;
            end
            if (wr_coll) begin
                write_collision_flag <= 1'b1;
            end else if (seq_clear) begin
                write_collision_flag <= 1'b0;
            end
            if (slave_select_error_flag_set) begin
                slave_select_error_flag <= 1'b1;
            end else if (!en) begin
                slave_select_error_flag <= 1'b0;
            end
            if (mode_fault_flag_set) begin
                mode_fault_flag <= 1'b1;
            end else if (!fault_cond || seq_clear) begin
                mode_fault_flag <= 1'b0;
            end
            // Arm on status read, disarm on data access.
            if (rd && hit_st) begin
                seq_armed <= 1'b1;
            end else if (data_acc) begin
                seq_armed <= 1'b0;
            end
        end
    end

    // Software registers and interrupt.
    wire [7:0] events;
    wire [7:0] status_rd;

    assign events = {done, wr_coll, slave_select_error_flag_set, mode_fault_flag_set, 4'h0};
    // Status view, reserved bits read zero.
    assign status_rd = {transfer_done_flag, write_collision_flag,
                        slave_select_error_flag, mode_fault_flag, 4'h0};

    always @(posedge CLOCK) begin
        if (RESET) begin
            spi_control <= `SRS_CONTROL_RESET;
            irq_status <= 8'h00;
            irq_mask <= 8'h00;
            IRQ <= 1'b0;
        end else begin
            if (wr && hit_ctl) begin
                spi_control <= PWDATA[7:0];
            end
            if (wr && hit_imask) begin
                irq_mask <= PWDATA[7:0] & 8'hF0;
            end
            if (wr && hit_ist) begin
                irq_status <= (irq_status & ~PWDATA[7:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // Read data captured in the setup phase.
    always @(posedge CLOCK) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup_ph) begin
            if (hit_ctl) begin
                PRDATA <= {24'h00_0000, spi_control};
            end else if (hit_st) begin
                PRDATA <= {24'h00_0000, status_rd};
            end else if (hit_data) begin
                PRDATA <= {24'h00_0000, rx_buf};
            end else if (hit_ist) begin
                PRDATA <= {24'h00_0000, irq_status};
            end else if (hit_imask) begin
                PRDATA <= {24'h00_0000, irq_mask};
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // Pin drivers; enables are low while driving.
    assign SCK_OUT = sck_lvl;
    assign SCK_OE_N = !m_mode;
    assign MOSI_OUT = out_bit;
    assign MOSI_OE_N = !m_mode;
    assign MISO_OUT = out_bit;
    assign MISO_OE_N = !selected;
endmodule // srs_spi

// *** verification/srs_peer.sv ***
// Behavioural slave peer on the serial link, facing the block as master.
// Assumes clock polarity 0 and the phase given by the bench while idle.
`timescale 1ns/10ps
module srs_peer (
    input logic sck,
    input logic mosi,
    input logic load,
    input logic cpha,
    input logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    logic mq = 1'b0;
    logic [7:0] rq = 8'h00;
    assign miso = mq;
    assign rx_byte = rq;
    // Bits leave on the edge that the phase names; the other edge samples.
    always @(posedge load or posedge sck or negedge sck) begin
        if (load) begin
            sh <= cpha ? tx_byte : {tx_byte[6:0], 1'b0};
            if (!cpha) mq <= tx_byte[7];
        end else if (sck == cpha) begin
            mq <= sh[7];
            sh <= {sh[6:0], ~sh[7]};
        end else begin
            rq <= {rq[6:0], mosi};
        end
    end
endmodule // srs_peer

// *** verification/srs_spi_properties.sv ***
// Checker for the serial port block, watching only its ports.
// Assumes the single clock and synchronous reset of the block.
`timescale 1ns/10ps
`include "srs_consts.vh"
module srs_spi_props (
    input wire CLOCK, input wire RESET, input wire PSEL,
    input wire PENABLE, input wire PWRITE, input wire [7:0] PADDR,
    input wire [31:0] PWDATA, input wire [31:0] PRDATA,
    input wire PREADY, input wire PSLVERR, input wire IRQ,
    input wire SCK_IN, input wire SCK_OUT, input wire SCK_OE_N,
    input wire MOSI_IN, input wire MOSI_OUT, input wire MOSI_OE_N,
    input wire MISO_IN, input wire MISO_OUT, input wire MISO_OE_N,
    input wire SS_N_IN
);
    reg sck_q = 1'b0;
    reg [7:0] gap = 8'hff;
    reg [2:0] code = 3'h0;
    wire acc = PSEL && PENABLE;
    wire ctl_wr = acc && PWRITE && PADDR == `SRS_OFF_CONTROL;
    wire mapped = PADDR >= 8'hc0 && PADDR <= 8'hd0 && PADDR[1:0] == 2'h0;
    wire [7:0] half = (code == 3'h7) ? 8'h40 : (8'h01 << code);
    always @(posedge CLOCK) begin
        sck_q <= SCK_OUT;
        if (ctl_wr) gap <= 8'hff;
        else if (SCK_OUT != sck_q) gap <= 8'h00;
        else if (gap != 8'hff) gap <= gap + 8'h01;
        if (RESET) code <= 3'h0;
        else if (ctl_wr) code <= {PWDATA[7], PWDATA[1:0]};
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    ready_high_a: assert property (PREADY) else $error("ready low");
    err_map_a: assert property (acc |-> PSLVERR == !mapped)
        else $error("slave error wrong");
    upper_zero_a: assert property (PRDATA[31:8] == 24'h00_0000)
        else $error("read upper bits set");
    reserved_zero_a: assert property (PSEL && !PENABLE && !PWRITE &&
        PADDR == `SRS_OFF_STATUS |=> PRDATA[3:0] == 4'h0)
        else $error("reserved status bits set");
    read_hold_a: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved");
    oe_pair_a: assert property (SCK_OE_N == MOSI_OE_N)
        else $error("clock and data enables differ");
    oe_excl_a: assert property (!MISO_OE_N |-> SCK_OE_N)
        else $error("master and slave drive together");
    rate_floor_a: assert property (SCK_OUT != sck_q |->
        gap >= half - 8'h01) else $error("serial clock too fast");
    irq_mask_off_a: assert property (acc && PWRITE &&
        PADDR == `SRS_OFF_IRQ_MASK && PWDATA[7:4] == 4'h0 |=> ##1 !IRQ)
        else $error("masked interrupt high");
    reset_quiet_a: assert property (disable iff (1'b0)
        RESET |=> !IRQ && PRDATA == 32'h0000_0000)
        else $error("outputs busy after reset");
    cover property (SCK_OUT != sck_q);
    cover property (IRQ);
    cover property (acc && PSLVERR);
endmodule // srs_spi_props
bind srs_spi srs_spi_props i_props (
    .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .SCK_IN(SCK_IN),
    .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .MOSI_IN(MOSI_IN),
    .MOSI_OUT(MOSI_OUT), .MOSI_OE_N(MOSI_OE_N), .MISO_IN(MISO_IN),
    .MISO_OUT(MISO_OUT), .MISO_OE_N(MISO_OE_N), .SS_N_IN(SS_N_IN));

// *** verification/srs_tb.sv ***
// Self-checking bench for the serial port block over its register bus.
// Assumes the peer model and the bound checker sit beside the block.
`timescale 1ns/10ps
`include "srs_consts.vh"
module testbench;
    logic CLOCK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic SS_N_IN = 1, sck_m = 0, load = 0, pcpha = 1, serr;
    logic [7:0] PADDR = 0, ptx = 0, tx, pk;
    logic [31:0] PWDATA = 0, rdata;
    logic [15:0] hi = 0, h0;
    wire [31:0] PRDATA;
    wire [7:0] prx;
    wire PREADY, PSLVERR, IRQ, SCK_OUT, SCK_OE_N, MOSI_OUT, MOSI_OE_N;
    wire MISO_OUT, MISO_OE_N, peer_miso;
    wire SCK_IN = SCK_OE_N ? sck_m : SCK_OUT;
    wire MOSI_IN = MOSI_OE_N ? 1'b0 : MOSI_OUT;
    wire MISO_IN = MISO_OE_N ? peer_miso : MISO_OUT;
    int failures = 0, cmp_count = 0, r, k;
    srs_spi i_dut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
        .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N),
        .MOSI_IN(MOSI_IN), .MOSI_OUT(MOSI_OUT), .MOSI_OE_N(MOSI_OE_N),
        .MISO_IN(MISO_IN), .MISO_OUT(MISO_OUT), .MISO_OE_N(MISO_OE_N),
        .SS_N_IN(SS_N_IN));
    srs_peer i_peer (.sck(SCK_IN), .mosi(MOSI_IN), .load(load), .cpha(pcpha),
        .tx_byte(ptx), .miso(peer_miso), .rx_byte(prx));
    initial forever #20 CLOCK = ~CLOCK;
    always @(posedge CLOCK) if (SCK_OUT === 1'b1) hi <= hi + 16'h0001;
    function automatic logic [31:0] ctl(input logic [2:0] c, input logic d,
        input logic p);
        return {24'h00_0000, c[2], 1'b1, d, 1'b1, 1'b0, p, c[1:0]};
    endfunction
    function automatic logic [15:0] high_count(input int c);
        return 16'h0008 << c;
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rdata = PRDATA;
        serr = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, e);
        apb(0, a, 0);
        chk(rdata[15:0] & m, e);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do apb(0, `SRS_OFF_STATUS, 0);
        while (rdata[7] !== 1'b1 && ++n < 600);
        if (n >= 600) failures++;
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge CLOCK);
        failures++;
        wrap_up;
    end
    initial begin
        r = $urandom(73);
        repeat (20) @(posedge CLOCK);
        RESET <= 0;
        rd(`SRS_OFF_CONTROL, 16'hffff, 16'h0014);
        rd(`SRS_OFF_STATUS, 16'hffff, 16'h0000);
        apb(0, 8'h10, 0);
        chk({15'h0000, serr}, 16'h0001);
        $display("test reset done");
        for (k = 0; k < 7; k++) begin
            tx = $urandom;
            pk = $urandom;
            ptx <= pk;
            pcpha <= k[0];
            load <= 1;
            apb(1, `SRS_OFF_CONTROL, ctl(k[2:0], 1'b1, k[0]));
            load <= 0;
            h0 = hi;
            apb(1, `SRS_OFF_DATA, {24'h00_0000, tx});
            wait_done;
            chk(hi - h0, high_count(k));
            rd(`SRS_OFF_STATUS, 16'h0080, 16'h0080);
            apb(0, `SRS_OFF_DATA, 0);
            if (k > 2) chk(rdata[15:0], {8'h00, pk});
            chk({8'h00, prx}, {8'h00, tx});
            rd(`SRS_OFF_STATUS, 16'h0080, 16'h0000);
            $display("test rate %0d done", k);
        end
        apb(1, `SRS_OFF_IRQ_MASK, 32'h0000_0040);
        apb(1, `SRS_OFF_CONTROL, ctl(3'h3, 1'b1, 1'b1));
        apb(1, `SRS_OFF_DATA, {24'h00_0000, tx});
        apb(1, `SRS_OFF_DATA, {24'h00_0000, pk});
        rd(`SRS_OFF_STATUS, 16'h0040, 16'h0040);
        chk({15'h0000, IRQ}, 16'h0001);
        apb(0, `SRS_OFF_DATA, 0);
        rd(`SRS_OFF_STATUS, 16'h0040, 16'h0000);
        apb(1, `SRS_OFF_IRQ_STATUS, 32'h0000_0040);
        repeat (2) @(posedge CLOCK);
        chk({15'h0000, IRQ}, 16'h0000);
        wait_done;
        $display("test collision done");
        apb(1, `SRS_OFF_IRQ_MASK, 32'h0000_0010);
        apb(1, `SRS_OFF_CONTROL, ctl(3'h3, 1'b0, 1'b1));
        SS_N_IN <= 0;
        repeat (4) @(posedge CLOCK);
        rd(`SRS_OFF_STATUS, 16'h0010, 16'h0010);
        chk({15'h0000, IRQ}, 16'h0001);
        SS_N_IN <= 1;
        repeat (4) @(posedge CLOCK);
        rd(`SRS_OFF_STATUS, 16'h0010, 16'h0000);
        apb(1, `SRS_OFF_IRQ_MASK, 0);
        repeat (2) @(posedge CLOCK);
        chk({15'h0000, IRQ}, 16'h0000);
        $display("test fault done");
        apb(1, `SRS_OFF_CONTROL, 32'h0000_0040);
        apb(1, `SRS_OFF_DATA, {24'h00_0000, tx});
        for (k = 16; k > 0; k -= 12) begin
            SS_N_IN <= 0;
            repeat (k) begin
                repeat (4) @(posedge CLOCK);
                if (!sck_m) pk = {pk[6:0], MISO_OUT};
                sck_m <= ~sck_m;
            end
            repeat (4) @(posedge CLOCK);
            SS_N_IN <= 1;
            repeat (4) @(posedge CLOCK);
            h0 = (k > 4) ? 16'h0080 : 16'h00a0;
            rd(`SRS_OFF_STATUS, 16'h00a0, h0);
            if (k > 4) chk({8'h00, pk}, {8'h00, tx});
        end
        apb(0, `SRS_OFF_DATA, 0);
        rd(`SRS_OFF_STATUS, 16'h0020, 16'h0020);
        apb(1, `SRS_OFF_CONTROL, 32'h0000_0004);
        rd(`SRS_OFF_STATUS, 16'h0020, 16'h0000);
        $display("test slave done");
        wrap_up;
    end
endmodule // testbench
